// file: src/pwr_pkg.sv
// Constants shared by the module-halt and speed-switch logic
package pwr_pkg;

    // =====================================================
    // Register byte addresses
    localparam logic [4:0] ADDR_HALT   = 5'h00;
    localparam logic [4:0] ADDR_STBY   = 5'h04;
    localparam logic [4:0] ADDR_LPWR   = 5'h08;
    localparam logic [4:0] ADDR_WDT    = 5'h0c;
    localparam logic [4:0] ADDR_STAT   = 5'h10;
    localparam logic [4:0] ADDR_HALTST = 5'h14;

    // =====================================================
    // Field positions
    localparam int STBY_SEL_BIT   = 7;
    localparam int SETTLE_LSB     = 4;
    localparam int DIV_LSB        = 0;
    localparam int LPWR_DIRECT_SWITCH_ENABLE_BIT  = 7;
    localparam int LPWR_LOW_SPEED_SELECT_BIT  = 6;
    localparam int WDT_PSS_BIT    = 4;
    localparam int STAT_RUN_BIT   = 0;
    localparam int STAT_LOW_BIT   = 1;
    localparam int STAT_SET_BIT   = 2;
    localparam int STAT_HOLD_BIT  = 3;

    // =====================================================
    // Reset values
    localparam logic [7:0]  STBY_RST = 8'h00;
    localparam logic [7:0]  LPWR_RST = 8'h00;
    localparam logic [7:0]  WDT_RST  = 8'h00;
    localparam logic [31:0] HALT_RST = 32'hffff_ffff;

    // =====================================================
    // Module masks and timing
    localparam logic [31:0] RETAIN_MASK_DEF  = 32'hffff_fff0;
    localparam logic [31:0] LOW_RUN_MASK_DEF = 32'h0000_00f0;
    localparam int unsigned SETTLE_BASE_DEF  = 8192;
    localparam int unsigned SETTLE_BASE_MIN  = 8;

    // =====================================================
    // Bus answers
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_DECERR = 2'b11;

    // =====================================================
    // Speed state
    typedef enum logic [3:0] {
        ST_HIGH   = 4'b0001,
        ST_SETTLE = 4'b0010,
        ST_LOW    = 4'b0100,
        ST_STBY   = 4'b1000
    } speed_state_e;

endpackage : pwr_pkg

// file: src/settle_if.sv
// Handshake between the speed sequencer and the settle timer
`timescale 1ns/1ps
interface settle_if;
    logic       start;
    logic [2:0] sel;
    logic       done;

    modport ctrl  (output start, output sel, input done);
    modport timer (input start, input sel, output done);
endinterface : settle_if

// file: src/settle_timer.sv
// Oscillation settle counter with selectable terminal count
`timescale 1ns/1ps
module settle_timer #(
    parameter int unsigned BASE_CYCLES = pwr_pkg::SETTLE_BASE_DEF
) (
    // Clock and control
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Sequencer side
    settle_if.timer  sif
);
    localparam int unsigned CW = $clog2(BASE_CYCLES) + 8;

    if (BASE_CYCLES < pwr_pkg::SETTLE_BASE_MIN) begin : g_chk
        $error("settle base count too small");
    end

    logic [CW-1:0] count_q;
    logic [CW-1:0] target_q;
    logic          run_q;
    logic          done_q;

    // =====================================================
    // Terminal count from select field
    wire [CW-1:0] target_w = CW'(CW'(BASE_CYCLES) << sif.sel) - CW'(1);
    wire          at_end   = run_q && (count_q == target_q);

    always_ff @(posedge clk) begin
        if (rst) begin
            count_q  <= '0;
            target_q <= '0;
            run_q    <= 1'b0;
            done_q   <= 1'b0;
        end else if (ce) begin
            done_q <= at_end;
            if (sif.start) begin
                run_q    <= 1'b1;
                count_q  <= '0;
                target_q <= target_w;
            end else if (at_end) begin
                run_q <= 1'b0;
            end else if (run_q) begin
                count_q <= count_q + CW'(1);
            end
        end
    end

    assign sif.done = done_q;

endmodule : settle_timer

// file: src/module_stop_and_speed_switch.sv
// Per-module halt control and high/low speed direct switching
//
// Summary of operation
// - Halt bit set stops module at cycle end
// - Halt bit cleared resumes module at cycle end
// - Each module has its own halt bit
// - Serial, modulators, converter lose state when halted
// - All modules halted after reset
// - Halted module register access is blocked
// - Switch to low speed never suspends instruction execution; switch to high suspends it during settle
// - Direct switch needs enable; then exception starts
// - High speed plus all bits: go low speed
// - Low speed, low select clear: settle, high
// - Standby keeps port pins as they were
// - Low speed: only timers and watchdogs run
`timescale 1ns/1ps
module module_stop_and_speed_switch #(
    parameter int unsigned NUM_MODULES        = 16,
    parameter logic [31:0] RETAIN_MASK        = pwr_pkg::RETAIN_MASK_DEF,
    parameter logic [31:0] LOW_RUN_MASK       = pwr_pkg::LOW_RUN_MASK_DEF,
    parameter int unsigned SETTLE_BASE_CYCLES = pwr_pkg::SETTLE_BASE_DEF
) (
    // Clock, reset, enable
    input  wire logic                   CORE_CLK,
    input  wire logic                   RST,
    input  wire logic                   CE,
    // Avalon-MM slave
    input  wire logic [4:0]             AVS_ADDRESS,
    input  wire logic                   AVS_READ,
    input  wire logic                   AVS_WRITE,
    input  wire logic [31:0]            AVS_WRITEDATA,
    input  wire logic [3:0]             AVS_BYTEENABLE,
    output logic      [31:0]            AVS_READDATA,
    output logic                        AVS_WAITREQUEST,
    output logic      [1:0]             AVS_RESPONSE,
    // CPU core
    input  wire logic                   SLEEP_REQ,
    input  wire logic                   WAKE_REQ,
    output logic                        CPU_RUN,
    output logic                        DIRECT_EXC,
    output logic                        CPU_SUBCLK_SEL,
    output logic                        PORT_HOLD,
    // Peripheral modules
    input  wire logic                   BUS_CYCLE_END,
    input  wire logic [NUM_MODULES-1:0] PERIPH_WR_REQ,
    input  wire logic [NUM_MODULES-1:0] PERIPH_RD_REQ,
    output logic      [NUM_MODULES-1:0] PERIPH_HALT,
    output logic      [NUM_MODULES-1:0] PERIPH_CLEAR,
    output logic      [NUM_MODULES-1:0] PERIPH_WR_EN,
    output logic      [NUM_MODULES-1:0] PERIPH_RD_EN
);

    if (NUM_MODULES < 1 || NUM_MODULES > 32) begin : g_chk
        $error("NUM_MODULES must be 1 to 32");
    end

    localparam logic [31:0] LIVE = 32'hffff_ffff >> (32 - NUM_MODULES);

    // =====================================================
    // Registers and state
    logic [31:0]                halt_reg_q;
    logic [7:0]                 stby_q;
    logic [7:0]                 lpwr_q;
    logic [7:0]                 wdt_q;
    logic [31:0]                halt_q;
    logic [31:0]                clear_q;
    logic [31:0]                wr_en_q;
    logic [31:0]                rd_en_q;
    logic                       wait_q;
    logic [31:0]                rdata_q;
    logic [1:0]                 resp_q;
    pwr_pkg::speed_state_e      state_q;
    pwr_pkg::speed_state_e      state_d;
    logic                       cpu_run_q;
    logic                       exc_q;
    logic                       subclk_q;
    logic                       hold_q;

    settle_if sif ();

    // =====================================================
    // Bus decode
    wire sel_halt   = AVS_ADDRESS == pwr_pkg::ADDR_HALT;
    wire sel_stby   = AVS_ADDRESS == pwr_pkg::ADDR_STBY;
    wire sel_lpwr   = AVS_ADDRESS == pwr_pkg::ADDR_LPWR;
    wire sel_wdt    = AVS_ADDRESS == pwr_pkg::ADDR_WDT;
    wire sel_stat   = AVS_ADDRESS == pwr_pkg::ADDR_STAT;
    wire sel_haltst = AVS_ADDRESS == pwr_pkg::ADDR_HALTST;
    wire hit        = sel_halt | sel_stby | sel_lpwr | sel_wdt | sel_stat | sel_haltst;
    wire accept     = (AVS_READ || AVS_WRITE) && wait_q;
    wire commit_wr  = AVS_WRITE && !wait_q;
    wire wr_byte0   = commit_wr && AVS_BYTEENABLE[0];

    wire [31:0] stat_w = {28'h0, hold_q, state_q == pwr_pkg::ST_SETTLE, subclk_q, cpu_run_q};
    wire [31:0] rd_mux = sel_halt   ? halt_reg_q :
                         sel_stby   ? {24'h0, stby_q} :
                         sel_lpwr   ? {24'h0, lpwr_q} :
                         sel_wdt    ? {24'h0, wdt_q} :
                         sel_stat   ? stat_w :
                         sel_haltst ? halt_q : 32'h0;

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h0;
            resp_q  <= pwr_pkg::RESP_OKAY;
        end else if (CE) begin
            wait_q <= !accept;
            if (accept) begin
                rdata_q <= AVS_READ ? rd_mux : 32'h0;
                resp_q  <= hit ? pwr_pkg::RESP_OKAY : pwr_pkg::RESP_DECERR;
            end
        end
    end

    // =====================================================
    // Control registers
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            stby_q <= pwr_pkg::STBY_RST;
            lpwr_q <= pwr_pkg::LPWR_RST;
            wdt_q  <= pwr_pkg::WDT_RST;
        end else if (CE && wr_byte0) begin
            if (sel_stby) stby_q <= AVS_WRITEDATA[7:0];
            if (sel_lpwr) lpwr_q <= AVS_WRITEDATA[7:0];
            if (sel_wdt)  wdt_q  <= AVS_WRITEDATA[7:0];
        end
    end

    for (genvar b = 0; b < 4; b++) begin : g_halt_byte
        always_ff @(posedge CORE_CLK) begin
            if (RST) begin
                halt_reg_q[8*b +: 8] <= pwr_pkg::HALT_RST[8*b +: 8] & LIVE[8*b +: 8];
            end else if (CE && commit_wr && sel_halt && AVS_BYTEENABLE[b]) begin
                halt_reg_q[8*b +: 8] <= AVS_WRITEDATA[8*b +: 8] & LIVE[8*b +: 8];
            end
        end
    end

    // =====================================================
    // Speed sequencer
    wire standby_select = stby_q[pwr_pkg::STBY_SEL_BIT];
    wire low_speed_select = lpwr_q[pwr_pkg::LPWR_LOW_SPEED_SELECT_BIT];
    wire direct_switch_enable = lpwr_q[pwr_pkg::LPWR_DIRECT_SWITCH_ENABLE_BIT];
    wire watchdog_prescaler_select  = wdt_q[pwr_pkg::WDT_PSS_BIT];

    wire in_high  = state_q == pwr_pkg::ST_HIGH;
    wire in_low   = state_q == pwr_pkg::ST_LOW;
    wire go_low   = SLEEP_REQ && in_high && standby_select && low_speed_select && direct_switch_enable && watchdog_prescaler_select;
    wire go_high  = SLEEP_REQ && in_low && standby_select && !low_speed_select && direct_switch_enable && watchdog_prescaler_select;
    wire go_stby  = SLEEP_REQ && (in_high || in_low) && standby_select && !direct_switch_enable;
    wire settled  = state_q == pwr_pkg::ST_SETTLE && sif.done;

    assign sif.start = CE && go_high;
    assign sif.sel   = stby_q[pwr_pkg::SETTLE_LSB +: 3];

    always_comb begin
        state_d = state_q;
        case (state_q)
            pwr_pkg::ST_HIGH: begin
                if (go_low) state_d = pwr_pkg::ST_LOW;
                else if (go_stby) state_d = pwr_pkg::ST_STBY;
            end
            pwr_pkg::ST_LOW: begin
                if (go_high) state_d = pwr_pkg::ST_SETTLE;
                else if (go_stby) state_d = pwr_pkg::ST_STBY;
            end
            pwr_pkg::ST_SETTLE: begin
                if (sif.done) state_d = pwr_pkg::ST_HIGH;
            end
            pwr_pkg::ST_STBY: begin
                if (WAKE_REQ) state_d = low_speed_select ? pwr_pkg::ST_LOW : pwr_pkg::ST_HIGH;
            end
            default: state_d = pwr_pkg::ST_HIGH;
        endcase
    end

    wire low_d  = state_d == pwr_pkg::ST_LOW || state_d == pwr_pkg::ST_SETTLE;
    wire run_d  = state_d == pwr_pkg::ST_HIGH || state_d == pwr_pkg::ST_LOW;
    wire exc_d  = go_low || settled;
    wire hold_d = state_d == pwr_pkg::ST_STBY;

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            state_q   <= pwr_pkg::ST_HIGH;
            cpu_run_q <= 1'b1;
            exc_q     <= 1'b0;
            subclk_q  <= 1'b0;
            hold_q    <= 1'b0;
        end else if (CE) begin
            state_q   <= state_d;
            cpu_run_q <= run_d;
            exc_q     <= exc_d;
            subclk_q  <= low_d;
            hold_q    <= hold_d;
        end
    end

    settle_timer #(
        .BASE_CYCLES (SETTLE_BASE_CYCLES)
    ) u_settle (
        .clk (CORE_CLK),
        .rst (RST),
        .ce  (CE),
        .sif (sif)
    );

    // =====================================================
    // Module halt and access gating
    wire        low_now  = state_q == pwr_pkg::ST_LOW || state_q == pwr_pkg::ST_SETTLE;
    wire [31:0] low_halt = low_now ? ~LOW_RUN_MASK : 32'h0;
    wire [31:0] stb_halt = (state_q == pwr_pkg::ST_STBY) ? 32'hffff_ffff : 32'h0;
    wire [31:0] eff_halt = (halt_reg_q | low_halt | stb_halt) & LIVE;
    wire [31:0] wr_req_w = 32'(PERIPH_WR_REQ);
    wire [31:0] rd_req_w = 32'(PERIPH_RD_REQ);

    for (genvar i = 0; i < 32; i++) begin : g_mod
        always_ff @(posedge CORE_CLK) begin
            if (RST) begin
                halt_q[i]  <= LIVE[i];
                clear_q[i] <= LIVE[i] & ~RETAIN_MASK[i];
                wr_en_q[i] <= 1'b0;
                rd_en_q[i] <= 1'b0;
            end else if (CE) begin
                if (BUS_CYCLE_END) begin
                    halt_q[i]  <= eff_halt[i];
                    clear_q[i] <= eff_halt[i] & ~RETAIN_MASK[i];
                end
                wr_en_q[i] <= wr_req_w[i] && !halt_q[i];
                rd_en_q[i] <= rd_req_w[i] && !halt_q[i];
            end
        end
    end

    // =====================================================
    // Outputs
    assign AVS_READDATA    = rdata_q;
    assign AVS_WAITREQUEST = wait_q;
    assign AVS_RESPONSE    = resp_q;
    assign CPU_RUN         = cpu_run_q;
    assign DIRECT_EXC      = exc_q;
    assign CPU_SUBCLK_SEL  = subclk_q;
    assign PORT_HOLD       = hold_q;
    assign PERIPH_HALT     = halt_q[NUM_MODULES-1:0];
    assign PERIPH_CLEAR    = clear_q[NUM_MODULES-1:0];
    assign PERIPH_WR_EN    = wr_en_q[NUM_MODULES-1:0];
    assign PERIPH_RD_EN    = rd_en_q[NUM_MODULES-1:0];

    // =====================================================
    // Assertions
    sequence s_low_cmd;
        CE && go_low;
    endsequence
    sequence s_high_cmd;
        CE && go_high;
    endsequence

    property p_halt_at_end;
        @(posedge CORE_CLK) disable iff (RST)
        (halt_q != $past(halt_q)) |-> $past(BUS_CYCLE_END && CE);
    endproperty
    a_halt_at_end: assert property (p_halt_at_end) else $error("halt moved off cycle end");

    property p_follow_reg;
        @(posedge CORE_CLK) disable iff (RST)
        (CE && BUS_CYCLE_END && in_high) |=> (halt_q == ($past(halt_reg_q) & LIVE));
    endproperty
    a_follow_reg: assert property (p_follow_reg) else $error("halt differs from its bit");

    property p_resume;
        @(posedge CORE_CLK) disable iff (RST)
        (CE && BUS_CYCLE_END && in_high && !halt_reg_q[0]) |=> !halt_q[0];
    endproperty
    a_resume: assert property (p_resume) else $error("module did not resume");

    property p_reset_halt;
        @(posedge CORE_CLK)
        RST |=> (halt_q == LIVE && halt_reg_q == LIVE);
    endproperty
    a_reset_halt: assert property (p_reset_halt) else $error("module not halted by reset");

    property p_no_access;
        @(posedge CORE_CLK) disable iff (RST)
        CE |=> (((wr_en_q | rd_en_q) & $past(halt_q)) == 32'h0);
    endproperty
    a_no_access: assert property (p_no_access) else $error("access to halted module");

    property p_clear_mask;
        @(posedge CORE_CLK) disable iff (RST)
        clear_q == (halt_q & ~RETAIN_MASK);
    endproperty
    a_clear_mask: assert property (p_clear_mask) else $error("state clear mismatch");

    property p_to_low;
        @(posedge CORE_CLK) disable iff (RST)
        s_low_cmd |=> (state_q == pwr_pkg::ST_LOW) && DIRECT_EXC && CPU_RUN && CPU_SUBCLK_SEL;
    endproperty
    a_to_low: assert property (p_to_low) else $error("no switch to low speed");

    property p_settle;
        @(posedge CORE_CLK) disable iff (RST)
        s_high_cmd |=> (!CPU_RUN && state_q == pwr_pkg::ST_SETTLE)[*8];
    endproperty
    a_settle: assert property (p_settle) else $error("settle wait cut short");

    property p_settle_end;
        @(posedge CORE_CLK) disable iff (RST)
        (CE && settled) |=> in_high && CPU_RUN && DIRECT_EXC && !CPU_SUBCLK_SEL;
    endproperty
    a_settle_end: assert property (p_settle_end) else $error("no high speed after settle");

    property p_exc_cause;
        @(posedge CORE_CLK) disable iff (RST)
        $rose(DIRECT_EXC) |-> $past(direct_switch_enable) || $past(state_q == pwr_pkg::ST_SETTLE);
    endproperty
    a_exc_cause: assert property (p_exc_cause) else $error("exception without enable");

    property p_low_runs;
        @(posedge CORE_CLK) disable iff (RST)
        in_low |-> CPU_RUN && CPU_SUBCLK_SEL;
    endproperty
    a_low_runs: assert property (p_low_runs) else $error("low speed suspended CPU");

    property p_low_halts;
        @(posedge CORE_CLK) disable iff (RST)
        (CE && BUS_CYCLE_END && in_low) |=> ((~halt_q & ~LOW_RUN_MASK & LIVE) == 32'h0);
    endproperty
    a_low_halts: assert property (p_low_halts) else $error("module runs at low speed");

    property p_hold;
        @(posedge CORE_CLK) disable iff (RST)
        (state_q == pwr_pkg::ST_STBY) |-> PORT_HOLD && !CPU_RUN;
    endproperty
    a_hold: assert property (p_hold) else $error("ports not held in standby");

endmodule : module_stop_and_speed_switch

// file: verif/cpu_bus_model.sv
// CPU side model: bus-cycle boundaries and peripheral register accesses
`timescale 1ns/1ps
module cpu_bus_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Bench control
    input  wire logic        bce_en,
    input  wire logic [15:0] acc_mask,
    // Towards the device
    output logic             bus_end,
    output logic [15:0]      wr_req,
    output logic [15:0]      rd_req
);
    logic [1:0] phase_q;

    // =====================================================
    // Four-state bus cycle, last state flagged
    always_ff @(posedge clk) begin
        if (rst) begin
            phase_q <= 2'h0;
        end else begin
            phase_q <= phase_q + 2'h1;
        end
    end
    assign bus_end = bce_en & (phase_q == 2'h3);
    // Writes in even states, reads in odd states
    assign wr_req  = phase_q[0] ? 16'h0000 : acc_mask;
    assign rd_req  = phase_q[0] ? acc_mask : 16'h0000;
endmodule : cpu_bus_model

// file: verif/testbench.sv
// Self-checking bench for halt control and speed switching
`timescale 1ns/1ps
module testbench;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic        sleep_req = 1'b0;
    logic        wake_req = 1'b0;
    logic        ce = 1'b1;
    logic        bce_en = 1'b0;
    logic [15:0] acc_mask = 16'h0000;
    logic [31:0] readdata;
    logic        waitreq;
    logic [1:0]  resp;
    logic        cpu_run;
    logic        direct_exc;
    logic        subclk;
    logic        port_hold;
    logic        bus_end;
    logic [15:0] wr_req;
    logic [15:0] rd_req;
    logic [15:0] halt;
    logic [15:0] clr;
    logic [15:0] wr_en;
    logic [15:0] rd_en;
    logic [3:0]  spd;
    int          n_errors = 0;
    int          tests_run = 0;
    int          n;

    localparam logic [15:0] KEEP = pwr_pkg::RETAIN_MASK_DEF[15:0];

    assign spd = {cpu_run, direct_exc, subclk, port_hold};

    always #2.5 core_clk = ~core_clk;

    module_stop_and_speed_switch #(.NUM_MODULES(16), .SETTLE_BASE_CYCLES(8)) dut (
        .CORE_CLK(core_clk), .RST(rst), .CE(ce),
        .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
        .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(readdata),
        .AVS_WAITREQUEST(waitreq), .AVS_RESPONSE(resp),
        .SLEEP_REQ(sleep_req), .WAKE_REQ(wake_req), .CPU_RUN(cpu_run), .DIRECT_EXC(direct_exc),
        .CPU_SUBCLK_SEL(subclk), .PORT_HOLD(port_hold),
        .BUS_CYCLE_END(bus_end), .PERIPH_WR_REQ(wr_req), .PERIPH_RD_REQ(rd_req),
        .PERIPH_HALT(halt), .PERIPH_CLEAR(clr), .PERIPH_WR_EN(wr_en), .PERIPH_RD_EN(rd_en)
    );

    cpu_bus_model cpu (
        .clk(core_clk), .rst(rst), .bce_en(bce_en), .acc_mask(acc_mask),
        .bus_end(bus_end), .wr_req(wr_req), .rd_req(rd_req)
    );

    // =====================================================
    // Checking and closing
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic final_report;
        if (n_errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    // =====================================================
    // Avalon-MM master
    task automatic avs_xfer(input logic wr, input logic [4:0] addr, input logic [31:0] wdata,
                            output logic [31:0] rdata, output logic [1:0] rsp);
        int k;
        k = 0;
        @(posedge core_clk);
        avs_address   <= addr;
        avs_writedata <= wdata;
        avs_write     <= wr;
        avs_read      <= ~wr;
        do begin
            @(posedge core_clk);
            k++;
        end while (waitreq !== 1'b0 && k < 50);
        rdata = readdata;
        rsp   = resp;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        if (k >= 50) chk("bus answer", 32'h1, 32'h0);
    endtask : avs_xfer

    task automatic avs_wr(input logic [4:0] addr, input logic [31:0] wdata);
        logic [31:0] d;
        logic [1:0]  r;
        avs_xfer(1'b1, addr, wdata, d, r);
    endtask : avs_wr

    task automatic avs_chk(input logic [4:0] addr, input logic [31:0] exp, input logic [1:0] rexp);
        logic [31:0] d;
        logic [1:0]  r;
        avs_xfer(1'b0, addr, 32'h0, d, r);
        chk("read data", exp, d);
        chk("read response", {30'h0, rexp}, {30'h0, r});
    endtask : avs_chk

    // =====================================================
    // Sequences
    task automatic wait_bus_end;
        int k;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (bus_end !== 1'b1 && k < 20);
        #1;
    endtask : wait_bus_end

    task automatic halt_step(input logic [15:0] val, input logic [15:0] prev);
        @(posedge core_clk);
        bce_en <= 1'b0;
        avs_wr(pwr_pkg::ADDR_HALT, {16'h0000, val});
        repeat (4) @(posedge core_clk);
        #1 chk("halt before cycle end", {16'h0, prev}, {16'h0, halt});
        @(posedge core_clk);
        bce_en <= 1'b1;
        wait_bus_end;
        chk("halt after cycle end", {16'h0, val}, {16'h0, halt});
        chk("clear", {16'h0, val & ~KEEP}, {16'h0, clr});
        repeat (2) @(posedge core_clk);
        #1 chk("access enables", {16'h0, ~val}, {16'h0, wr_en | rd_en});
    endtask : halt_step

    task automatic sleep_pulse;
        @(posedge core_clk);
        sleep_req <= 1'b1;
        @(posedge core_clk);
        sleep_req <= 1'b0;
        #1;
    endtask : sleep_pulse

    // =====================================================
    // Main sequence
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        acc_mask <= 16'hffff;
        #1 chk("halt at reset", 32'h0000_ffff, {16'h0, halt});
        chk("clear at reset", {16'h0, ~KEEP}, {16'h0, clr});
        chk("speed at reset", 32'h8, {28'h0, spd});
        avs_chk(pwr_pkg::ADDR_HALT, 32'h0000_ffff, pwr_pkg::RESP_OKAY);
        avs_chk(pwr_pkg::ADDR_STAT, 32'h1, pwr_pkg::RESP_OKAY);
        chk("enables while halted", 32'h0, {16'h0, wr_en | rd_en});
        avs_chk(5'h1c, 32'h0, pwr_pkg::RESP_DECERR);
        halt_step(16'hfffe, 16'hffff);
        halt_step(16'h0001, 16'hfffe);
        avs_chk(pwr_pkg::ADDR_HALTST, 32'h1, pwr_pkg::RESP_OKAY);
        halt_step(16'h0000, 16'h0001);
        // Divider select left at zero ahead of low speed
        avs_wr(pwr_pkg::ADDR_STBY, 32'h80);
        avs_wr(pwr_pkg::ADDR_LPWR, 32'hc0);
        avs_wr(pwr_pkg::ADDR_WDT, 32'h00);
        sleep_pulse;
        chk("sleep without prescaler bit", 32'h8, {28'h0, spd});
        avs_wr(pwr_pkg::ADDR_WDT, 32'h10);
        sleep_pulse;
        chk("switch to low speed", 32'he, {28'h0, spd});
        @(posedge core_clk);
        #1 chk("exception pulse ends", 32'ha, {28'h0, spd});
        repeat (8) @(posedge core_clk);
        #1 chk("modules at low speed", {16'h0, ~pwr_pkg::LOW_RUN_MASK_DEF[15:0]}, {16'h0, halt});
        avs_chk(pwr_pkg::ADDR_STAT, 32'h3, pwr_pkg::RESP_OKAY);
        avs_wr(pwr_pkg::ADDR_STBY, 32'h90);
        avs_wr(pwr_pkg::ADDR_LPWR, 32'h80);
        sleep_pulse;
        chk("settle entry", 32'h2, {28'h0, spd});
        n = 0;
        while (cpu_run === 1'b0 && n < 200) begin
            @(posedge core_clk);
            #1 n++;
        end
        chk("settle length", (32'd8 << 1) + 32'd1, n);
        chk("high speed reached", 32'hc, {28'h0, spd});
        repeat (8) @(posedge core_clk);
        #1 chk("modules after high speed", 32'h0, {16'h0, halt});
        // Clock enable low freezes the halt state
        @(posedge core_clk);
        bce_en <= 1'b0;
        avs_wr(pwr_pkg::ADDR_HALT, 32'h0000_0005);
        ce     <= 1'b0;
        bce_en <= 1'b1;
        repeat (8) @(posedge core_clk);
        #1 chk("halt frozen", 32'h0, {16'h0, halt});
        @(posedge core_clk);
        ce <= 1'b1;
        wait_bus_end;
        chk("halt after freeze", 32'h5, {16'h0, halt});
        avs_wr(pwr_pkg::ADDR_STBY, 32'h80);
        avs_wr(pwr_pkg::ADDR_LPWR, 32'h00);
        sleep_pulse;
        repeat (2) @(posedge core_clk);
        #1 chk("standby", 32'h1, {28'h0, spd});
        sleep_pulse;
        chk("sleep in standby", 32'h1, {28'h0, spd});
        @(posedge core_clk);
        wake_req <= 1'b1;
        n = 0;
        while (cpu_run !== 1'b1 && n < 50) begin
            @(posedge core_clk);
            #1 n++;
        end
        chk("wake to high speed", 32'h4, {29'h0, cpu_run, subclk, port_hold});
        @(posedge core_clk);
        wake_req <= 1'b0;
        avs_wr(pwr_pkg::ADDR_STAT, 32'hff);
        avs_chk(pwr_pkg::ADDR_STAT, 32'h1, pwr_pkg::RESP_OKAY);
        final_report;
    end

    // =====================================================
    // Watchdog
    initial begin
        #(5 * 20000);
        n_errors++;
        final_report;
    end
endmodule : testbench
